// ==== anpas_pkg.sv ====
/*
  Constants for the auto-negotiation partner ability and expansion status
  register bank: register offsets, field positions, reset values.
  Assumes a 5-bit register address from the management serial port logic.
*/
package anpas_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_PARTNER_BASE = 5'h05;
  localparam logic [4:0] OFS_EXPANSION = 5'h06;
  // ----------------------------------------------------------------
  // expansion field positions
  // ----------------------------------------------------------------
  localparam int EXP_BASE_PAGE = 5;
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP_ABLE = 3;
  localparam int EXP_NP_ABLE = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_LP_AN_ABLE = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PARTNER_BASE = 16'h0000;
  localparam logic RST_NP_ABLE = 1'b1;
  localparam logic [4:0] RST_SELECTOR = 5'h00;
  // ----------------------------------------------------------------
  // partner base page field positions
  // ----------------------------------------------------------------
  localparam int BASE_NEXT_PAGE = 15;
  localparam int BASE_ACK = 14;
  localparam int BASE_REMOTE_FAULT = 13;
  localparam int BASE_ASYM_PAUSE = 11;
  localparam int BASE_PAUSE = 10;
  localparam int BASE_TECH_HI = 9;
  localparam int BASE_TECH_LO = 5;
  localparam int BASE_SEL_HI = 4;
  localparam int BASE_SEL_LO = 0;
  // lowest reserved bit of the expansion register
  localparam int EXP_RSVD_LO = 6;
endpackage : anpas_pkg

// ==== anpas_regs.sv ====
/*
  Partner base-page ability register and auto-negotiation expansion
  status register for one port. Assumes the negotiation engine runs on
  sys_clk and gives one-cycle load strobes and level status signals, and
  that the management port gives a one-cycle read strobe with an address.
*/
`timescale 1ns/1ns
module anpas_regs (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic alt_next_page,
  input wire logic base_load,
  input wire logic next_load,
  input wire logic [15:0] rx_code_word,
  input wire logic base_page,
  input wire logic pd_fault,
  input wire logic lp_np_able,
  input wire logic lp_an_able,
  input wire logic page_rx,
  input wire logic transmit_disable
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every value that crosses a clock edge lives in this one word
  typedef struct packed {
    logic [15:0] partner_base; // partner base page word
    logic base_page_l; // latched base_page, 6.5
    logic pd_fault_l; // latched parallel detection fault, 6.4
    logic page_rx_l; // latched page received, 6.1
    logic np_able; // local next page ability, 6.2
    logic page_rx_q; // page_rx one cycle back
    logic tx_dis_q; // transmit_disable one cycle back
    logic [15:0] rdata; // registered read data
  } anpas_state_t;

  anpas_state_t st;
  anpas_state_t next_st;
  logic rd_base;
  logic rd_exp;
  logic base_take;
  logic page_new;
  logic page_rx_fall;
  logic tx_dis_rise;
  logic page_clr;
  logic base_page_set;
  logic [15:0] exp_word;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // a read strobe selects at most one register; other addresses read 0
  assign rd_base = reg_rd && (reg_addr == anpas_pkg::OFS_PARTNER_BASE);
  assign rd_exp = reg_rd && (reg_addr == anpas_pkg::OFS_EXPANSION);

  base_read_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_base |=> reg_rdata == $past(st.partner_base))
    else $error("base register read returned wrong word");

  // ----------------------------------------------------------------
  // partner base page capture
  // ----------------------------------------------------------------
  // both strobes at once count as a next page: next pages belong to the
  // next page register, so only a lone base strobe overwrites this word
  assign base_take = base_load && !next_load;
  // either kind of loaded page raises page received
  assign page_new = base_load || next_load;

  base_capture_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    base_take |=> st.partner_base == $past(rx_code_word))
    else $error("base page not captured");

  ack_field_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    base_take |=> st.partner_base[anpas_pkg::BASE_ACK]
      == $past(rx_code_word[anpas_pkg::BASE_ACK]))
    else $error("acknowledge bit not captured");

  remote_fault_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    base_take |=> st.partner_base[anpas_pkg::BASE_REMOTE_FAULT]
      == $past(rx_code_word[anpas_pkg::BASE_REMOTE_FAULT]))
    else $error("remote fault bit not captured");

  pause_bits_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    base_take |=> {st.partner_base[anpas_pkg::BASE_ASYM_PAUSE],
      st.partner_base[anpas_pkg::BASE_PAUSE]}
      == $past({rx_code_word[anpas_pkg::BASE_ASYM_PAUSE],
      rx_code_word[anpas_pkg::BASE_PAUSE]}))
    else $error("pause bits not captured");

  tech_field_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    base_take |=> st.partner_base[anpas_pkg::BASE_TECH_HI:
      anpas_pkg::BASE_TECH_LO] == $past(rx_code_word[
      anpas_pkg::BASE_TECH_HI:anpas_pkg::BASE_TECH_LO]))
    else $error("technology bits not captured");

  selector_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    base_take |=> st.partner_base[anpas_pkg::BASE_SEL_HI:
      anpas_pkg::BASE_SEL_LO] == $past(rx_code_word[
      anpas_pkg::BASE_SEL_HI:anpas_pkg::BASE_SEL_LO]))
    else $error("selector not captured");

  selector_reset_a: assert property (@(posedge sys_clk)
    $fell(sys_rst) |-> st.partner_base[anpas_pkg::BASE_SEL_HI:
      anpas_pkg::BASE_SEL_LO] == anpas_pkg::RST_SELECTOR)
    else $error("selector not zero after reset");

  next_no_store_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    next_load |=> $stable(st.partner_base))
    else $error("next page written to base register");

  // ----------------------------------------------------------------
  // expansion status word
  // ----------------------------------------------------------------
  // live view of the expansion register; the reserved bits stay zero
  // because the register has no write path at all
  always_comb
  begin
    exp_word = 16'h0000;
    exp_word[anpas_pkg::EXP_BASE_PAGE] = st.base_page_l;
    exp_word[anpas_pkg::EXP_PD_FAULT] = st.pd_fault_l;
    exp_word[anpas_pkg::EXP_LP_NP_ABLE] = lp_np_able;
    exp_word[anpas_pkg::EXP_NP_ABLE] = st.np_able;
    exp_word[anpas_pkg::EXP_PAGE_RX] = st.page_rx_l;
    exp_word[anpas_pkg::EXP_LP_AN_ABLE] = lp_an_able;
  end

  exp_reserved_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_exp |=> reg_rdata[15:anpas_pkg::EXP_RSVD_LO] == 10'h000)
    else $error("reserved expansion bits nonzero");

  lp_np_able_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_exp |=> reg_rdata[anpas_pkg::EXP_LP_NP_ABLE] == $past(lp_np_able))
    else $error("partner next page able wrong");

  np_able_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_exp |=> reg_rdata[anpas_pkg::EXP_NP_ABLE])
    else $error("local next page able not reported");

  an_able_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_exp |=> reg_rdata[anpas_pkg::EXP_LP_AN_ABLE] == $past(lp_an_able))
    else $error("partner an able wrong");

  // ----------------------------------------------------------------
  // alternate clear of page received
  // ----------------------------------------------------------------
  // one-cycle events made from the two level inputs; the delayed copies
  // reset low, so a rise seen right after reset only clears a flag that
  // reset has already cleared
  assign page_rx_fall = st.page_rx_q && !page_rx;
  assign tx_dis_rise = !st.tx_dis_q && transmit_disable;
  // the extra clear only exists with alternate next page switched on
  assign page_clr = alt_next_page && (page_rx_fall || tx_dis_rise);

  page_alt_clr_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    page_clr && !page_new |=> !st.page_rx_l)
    else $error("page received not cleared by alt clear");

  rx_fall_clr_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    alt_next_page && page_rx_fall && !page_new |=> !st.page_rx_l)
    else $error("page received kept after page_rx fell");

  tx_rise_clr_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    alt_next_page && tx_dis_rise && !page_new |=> !st.page_rx_l)
    else $error("page received kept after transmit disable");

  alt_off_keep_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !alt_next_page && st.page_rx_l && !rd_exp |=> st.page_rx_l)
    else $error("page received lost without a read");

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // base_page only latches while alternate next page is on, where the
  // flag has a meaning; elsewhere it is never set and only a read clears it
  assign base_page_set = alt_next_page && base_page;

  // capture, latch and clear on read; in every latch the set term is
  // or-ed after the clear, so an event in the read cycle is kept
  always_comb
  begin
    next_st = st;
    next_st.page_rx_q = page_rx;
    next_st.tx_dis_q = transmit_disable;
    if (base_take)
    begin
      next_st.partner_base = rx_code_word;
    end
    next_st.base_page_l = (st.base_page_l && !rd_exp)
      || base_page_set;
    next_st.pd_fault_l = (st.pd_fault_l && !rd_exp) || pd_fault;
    next_st.page_rx_l = (st.page_rx_l && !rd_exp && !page_clr)
      || page_new;
    // registered answer: the word as it stood at the read edge
    if (rd_base)
    begin
      next_st.rdata = st.partner_base;
    end
    else if (rd_exp)
    begin
      next_st.rdata = exp_word;
    end
    else
    begin
      next_st.rdata = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronous reset; the local next page ability is the only bit
  // that comes out of reset high
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.partner_base <= anpas_pkg::RST_PARTNER_BASE;
      st.np_able <= anpas_pkg::RST_NP_ABLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // read data straight from a flip-flop
  assign reg_rdata = st.rdata;

  // ----------------------------------------------------------------
  // latching flag checks
  // ----------------------------------------------------------------
  base_set_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    base_page_set |=> st.base_page_l)
    else $error("base page flag not latched");

  base_alt_only_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !alt_next_page && !st.base_page_l |=> !st.base_page_l)
    else $error("base page flag set without alternate next page");

  base_read_clr_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_exp && !base_page_set |=> !st.base_page_l)
    else $error("base page flag not cleared by read");

  pd_set_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    pd_fault |=> st.pd_fault_l)
    else $error("fault not latched");

  pd_hold_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    st.pd_fault_l && !rd_exp |=> st.pd_fault_l)
    else $error("fault latch lost before a read");

  page_set_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    page_new |=> st.page_rx_l)
    else $error("page received not set");

  page_read_clr_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_exp && !page_new |=> !st.page_rx_l)
    else $error("page received not cleared by read");

  read_clear_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_exp && !pd_fault |=> !st.pd_fault_l)
    else $error("latch not cleared by read");

  relatch_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_exp && pd_fault |=> st.pd_fault_l)
    else $error("active fault lost on read");

  // ----------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------
  page_read_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    base_load ##[1:8] rd_exp);

  fault_read_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    pd_fault ##1 !pd_fault ##[1:8] rd_exp);

  alt_clear_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    next_load ##[1:8] page_clr);

  base_latch_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    base_page_set ##[1:8] rd_exp);

  relatch_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    rd_exp && pd_fault);
endmodule : anpas_regs

// ==== anpas_link_partner.sv ====
/*
  Remote link partner model: hands one received code word to the block
  with a one-cycle load strobe. Assumes calls come from the bench.
*/
`timescale 1ns/1ns
module anpas_link_partner (
  input wire logic sys_clk,
  output logic base_load,
  output logic next_load,
  output logic [15:0] rx_code_word
);
  // idle: no strobe, word all ones
  initial
  begin
    base_load = 1'h0;
    next_load = 1'h0;
    rx_code_word = 16'hFFFF;
  end
  // word is inverted outside the strobe so stale data never matches
  task send_page(input logic nxt, input logic [15:0] w);
    @(negedge sys_clk);
    base_load = ~nxt;
    next_load = nxt;
    rx_code_word = w;
    @(negedge sys_clk);
    base_load = 1'h0;
    next_load = 1'h0;
    rx_code_word = ~w;
  endtask : send_page
endmodule : anpas_link_partner

// ==== testbench.sv ====
/*
  Self-checking bench for anpas_regs. Assumes anpas_pkg and the link
  partner model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic sys_clk = 0, sys_rst = 1, reg_rd = 0, alt_next_page = 0;
  logic base_page = 0, pd_fault = 0, lp_np_able = 0, lp_an_able = 0;
  logic page_rx = 0, transmit_disable = 0, base_load, next_load;
  logic [4:0] reg_addr = 0;
  logic [15:0] reg_rdata, rx_code_word;
  int fails = 0, comparisons = 0;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  anpas_regs anpas_regs_inst (.sys_clk, .sys_rst, .reg_addr, .reg_rd,
    .reg_rdata, .alt_next_page, .base_load, .next_load, .rx_code_word,
    .base_page, .pd_fault, .lp_np_able, .lp_an_able, .page_rx,
    .transmit_disable);
  anpas_link_partner anpas_link_partner_inst (.sys_clk, .base_load,
    .next_load, .rx_code_word);
  // one read strobe, compare the answer the cycle after
  task rd_chk(input logic [4:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge sys_clk);
    `CHK(reg_rdata, e)
    reg_rd = 1'h0;
    @(negedge sys_clk);
  endtask : rd_chk
  task reset_values;
    rd_chk(5'h05, anpas_pkg::RST_PARTNER_BASE);
    rd_chk(5'h06, 16'h0004);
    rd_chk(5'h07, 16'h0000);
  endtask : reset_values
  task base_pages;
    anpas_link_partner_inst.send_page(1'h0, 16'hEFE1);
    rd_chk(5'h05, 16'hEFE1);
    rd_chk(5'h06, 16'h0006);
    rd_chk(5'h06, 16'h0004);
    anpas_link_partner_inst.send_page(1'h0, 16'h0002);
    anpas_link_partner_inst.send_page(1'h1, 16'h1234);
    rd_chk(5'h05, 16'h0002);
    rd_chk(5'h06, 16'h0006);
  endtask : base_pages
  task latches;
    lp_np_able = 1'h1;
    lp_an_able = 1'h1;
    pd_fault = 1'h1;
    @(negedge sys_clk); // let the fault latch before the read
    rd_chk(5'h06, 16'h001D);
    rd_chk(5'h06, 16'h001D);
    pd_fault = 1'h0;
    rd_chk(5'h06, 16'h001D);
    rd_chk(5'h06, 16'h000D);
    lp_np_able = 1'h0;
    lp_an_able = 1'h0;
  endtask : latches
  task alt_page;
    alt_next_page = 1'h1;
    base_page = 1'h1;
    page_rx = 1'h1;
    anpas_link_partner_inst.send_page(1'h0, 16'h0001);
    base_page = 1'h0;
    rd_chk(5'h06, 16'h0026);
    anpas_link_partner_inst.send_page(1'h0, 16'h0001);
    page_rx = 1'h0;
    @(negedge sys_clk); // alt clear lands before the read
    rd_chk(5'h06, 16'h0004);
    page_rx = 1'h1;
    anpas_link_partner_inst.send_page(1'h0, 16'h0001);
    transmit_disable = 1'h1;
    @(negedge sys_clk); // alt clear lands before the read
    rd_chk(5'h06, 16'h0004);
  endtask : alt_page
  task results;
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  // reset for 8 cycles, then the scenarios
  initial
  begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'h0;
    reset_values;
    base_pages;
    latches;
    alt_page;
    results;
  end
  // watchdog: the tests take well under 100 cycles
  initial
  begin
    #20000;
    fails++;
    results;
  end
endmodule : testbench
